// ==== fls_pkg.sv ====
package fls_pkg;

	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;

	// Bus timing at the 40 MHz host clock
	localparam int CLK_PERIOD_NS = 25;
	localparam int T_ACC_NS      = 70;
	localparam int T_WE_PULSE_NS = 40;
	localparam logic [3:0] ACC_CYC  = 4'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] WE_CYC   = 4'((T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] SYNC_CYC = 4'h3;
	localparam logic [3:0] RD_CYC   = 4'(ACC_CYC + SYNC_CYC + 4'h1);

	// Command cycle addresses and codes
	localparam logic [ADDR_W-1:0] UNL_A1 = 22'h000555;
	localparam logic [ADDR_W-1:0] UNL_A2 = 22'h0002aa;
	localparam logic [DATA_W-1:0] UNL_D1 = 16'h00aa;
	localparam logic [DATA_W-1:0] UNL_D2 = 16'h0055;
	localparam logic [DATA_W-1:0] PROG_D         = 16'h00a0;
	localparam logic [DATA_W-1:0] ERASE_SETUP_D  = 16'h0080;
	localparam logic [DATA_W-1:0] SECTOR_ERASE_D = 16'h0030;
	localparam logic [DATA_W-1:0] UNLOCK1_D      = 16'h0060;
	localparam logic [DATA_W-1:0] UNLOCK2_D      = 16'h00d0;
	localparam logic [DATA_W-1:0] CFG_SET_D      = 16'h00d0;
	localparam logic [DATA_W-1:0] ID_ENTRY_D     = 16'h0090;
	localparam logic [DATA_W-1:0] ID_EXIT_D      = 16'h00f0;

	// Word offset of the lock state within a sector
	localparam logic [ADDR_W-1:0] LOCK_OFFSET = 22'h000002;

	// Data bit positions
	localparam int BIT_VOLATILE   = 0;
	localparam int BIT_PERSISTENT = 1;
	localparam int BIT_VPP_FAULT  = 3;
	localparam int BIT_FAILURE    = 5;
	localparam int BIT_TOGGLE     = 6;
	localparam int BIT_POLLING    = 7;

	localparam logic [1:0] CFG_AUTO_RETURN = 2'h0;
	localparam logic [1:0] CFG_HOLD_STATUS = 2'h1;
	localparam logic [1:0] CFG_RESET       = 2'h0;

	typedef enum logic [2:0] {
		FLS_READ,
		FLS_PROGRAM,
		FLS_ERASE_SECTOR,
		FLS_UNLOCK,
		FLS_READ_LOCK,
		FLS_SET_CFG,
		FLS_ID_EXIT
	} fls_cmd_t;

	typedef struct packed {
		fls_cmd_t            cmd;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   data;
	} fls_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   data;
	} fls_bus_t;

endpackage

// ==== fls_pin_sync.sv ====
`timescale 1ns/1ps
module fls_pin_sync #(
	parameter int WIDTH = 16
) (
	input  wire logic             i_mclk,  // Host clock
	input  wire logic             i_rst_b, // Sync reset, active low
	input  wire logic [WIDTH-1:0] i_pin,   // Asynchronous pin level
	output logic      [WIDTH-1:0] o_level  // Filtered level
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= i_pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// A bit changes only once the second and third stages agree
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge i_mclk) begin
				if (!i_rst_b)
					o_level[g] <= 1'b0;
				else if (s2[g] == s3[g])
					o_level[g] <= s3[g];
			end
		end
	endgenerate
endmodule // fls_pin_sync

// ==== fls_ctrl.sv ====
`timescale 1ns/1ps
// How it works
// - Configuration 01: status holds after success until identification exit.
// - After any failure status holds until identification exit is written.
// - Host writes identification exit once bit 5 reads 1 on a second toggling poll.
// - Bit 3 high means low program voltage; host then writes identification exit.
// - Host may poll anytime, combining toggle with failure and voltage bits.
module fls_ctrl
	import fls_pkg::*;
(
	input  wire logic                    i_mclk,          // 40 MHz clock
	input  wire logic                    i_rst_b,         // Sync reset, active low
	input  wire fls_pkg::fls_req_t       i_req,           // Command, address, data
	input  wire logic                    i_req_valid,     // Request strobe
	output logic                         o_req_ready,     // Ready for a request
	output logic                         o_done,          // Completion pulse
	output logic [fls_pkg::DATA_W-1:0]   o_rdata,         // Read word
	output logic [1:0]                   o_lock_state,    // Persistent, volatile
	output logic                         o_fail,          // Operation failed
	output logic                         o_vpp_fault,     // Program voltage fault
	output logic [1:0]                   o_cfg,           // Status configuration copy
	input  wire logic                    i_write_protect, // Wanted protect pin level
	input  wire logic                    i_flash_reset,   // Request device reset
	output logic                         o_ce_b,          // Chip enable, low
	output logic                         o_oe_b,          // Output enable, low
	output logic                         o_we_b,          // Write enable, low
	output logic                         o_reset_b,       // Device reset, low
	output logic                         o_wp,            // Write protect pin
	output logic [fls_pkg::ADDR_W-1:0]   o_addr,          // Address pins
	output logic [fls_pkg::DATA_W-1:0]   o_dq,            // Data pin drive value
	output logic                         o_dq_oe,         // Data pin drive enable
	input  wire logic [fls_pkg::DATA_W-1:0] i_dq          // Data pin level
);
	import fls_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD,
		ST_RD, ST_GAP, ST_STEP} fls_state_t;
	typedef enum logic [2:0] {PH_CMD, PH_READ, PH_POLL, PH_EXIT} fls_phase_t;

	fls_state_t            state;
	fls_phase_t            phase;
	fls_req_t              req;
	logic [2:0]            step;
	logic [3:0]            cnt;
	logic [DATA_W-1:0]     dq_level;
	logic [DATA_W-1:0]     rd_word;
	logic [DATA_W-1:0]     prev_word;
	logic                  prev_valid;
	logic                  fault_seen;
	fls_bus_t              next_bus;

	fls_pin_sync #(.WIDTH(DATA_W)) u_dq_sync (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_pin   (i_dq),
		.o_level (dq_level)
	);

	////////////////////////////////////////////////////////////////////////////
	// Command cycle tables

	function automatic logic [2:0] seq_len(input fls_cmd_t c);
		unique case (c)
			FLS_READ:         seq_len = 3'h0;
			FLS_PROGRAM:      seq_len = 3'h4;
			FLS_ERASE_SECTOR: seq_len = 3'h6;
			FLS_UNLOCK:       seq_len = 3'h2;
			FLS_READ_LOCK:    seq_len = 3'h3;
			FLS_SET_CFG:      seq_len = 3'h4;
			FLS_ID_EXIT:      seq_len = 3'h1;
		endcase
	endfunction

	function automatic fls_bus_t seq_word(input fls_req_t r, input logic [2:0] s);
		fls_bus_t w;
		if (s[0])
			w = '{addr: UNL_A2, data: UNL_D2};
		else
			w = '{addr: UNL_A1, data: UNL_D1};
		unique case (r.cmd)
			FLS_PROGRAM: begin
				if (s == 3'h2)
					w = '{addr: UNL_A1, data: PROG_D};
				if (s == 3'h3)
					w = '{addr: r.addr, data: r.data};
			end
			FLS_ERASE_SECTOR: begin
				if (s == 3'h2)
					w = '{addr: UNL_A1, data: ERASE_SETUP_D};
				// Second unlock pair restarts at the first unlock word
				if (s == 3'h3)
					w = '{addr: UNL_A1, data: UNL_D1};
				if (s == 3'h4)
					w = '{addr: UNL_A2, data: UNL_D2};
				if (s == 3'h5)
					w = '{addr: r.addr, data: SECTOR_ERASE_D};
			end
			FLS_UNLOCK: begin
				// Refused by the device under a live persistent lock with protect low
				w = '{addr: r.addr, data: (s[0] ? UNLOCK2_D : UNLOCK1_D)};
			end
			FLS_SET_CFG: begin
				if (s == 3'h2)
					w = '{addr: UNL_A1, data: CFG_SET_D};
				if (s == 3'h3)
					w = '{addr: UNL_A1, data: {14'h0000, r.data[1:0]}};
			end
			FLS_READ_LOCK: begin
				if (s == 3'h2)
					w = '{addr: UNL_A1, data: ID_ENTRY_D};
			end
			FLS_ID_EXIT: w = '{addr: UNL_A1, data: ID_EXIT_D};
			FLS_READ:    w = '{addr: r.addr, data: '0};
		endcase
		return w;
	endfunction

	always_comb begin
		if (phase == PH_EXIT)
			next_bus = '{addr: UNL_A1, data: ID_EXIT_D};
		else
			next_bus = seq_word(req, step);
	end

	assign o_req_ready = (state == ST_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// Pin levels owned by the host

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_reset_b <= 1'b0;
			o_wp      <= 1'b0;
		end else begin
			o_reset_b <= ~i_flash_reset;
			o_wp      <= i_write_protect;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus cycle engine

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			state          <= ST_IDLE;
			cnt            <= 4'h0;
			o_ce_b         <= 1'b1;
			o_oe_b         <= 1'b1;
			o_we_b         <= 1'b1;
			o_dq_oe        <= 1'b0;
			o_addr         <= '0;
			o_dq           <= '0;
			rd_word        <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (i_req_valid) begin
						o_addr <= i_req.addr;
						if (seq_len(i_req.cmd) == 3'h0) begin
							state  <= ST_RD;
							o_ce_b <= 1'b0;
							o_oe_b <= 1'b0;
							cnt    <= RD_CYC;
						end else begin
							state <= ST_WR_SETUP;
						end
					end
				end
				ST_STEP: begin
					if (phase == PH_READ) begin
						o_addr <= req.addr + LOCK_OFFSET;
						state  <= ST_RD;
						o_ce_b <= 1'b0;
						o_oe_b <= 1'b0;
						cnt    <= RD_CYC;
					end else if (phase == PH_POLL) begin
						o_addr <= req.addr;
						state  <= ST_RD;
						o_ce_b <= 1'b0;
						o_oe_b <= 1'b0;
						cnt    <= RD_CYC;
					end else if (phase == PH_CMD && o_done) begin
						// The gap just passed judged the sequence finished
						state <= ST_IDLE;
					end else begin
						state <= ST_WR_SETUP;
					end
				end
				ST_WR_SETUP: begin
					o_addr  <= next_bus.addr;
					o_dq    <= next_bus.data;
					o_dq_oe <= 1'b1;
					o_ce_b  <= 1'b0;
					state   <= ST_WR_PULSE;
					cnt     <= WE_CYC;
				end
				ST_WR_PULSE: begin
					o_we_b <= 1'b0;
					cnt    <= cnt - 4'h1;
					if (cnt == 4'h1)
						state <= ST_WR_HOLD;
				end
				ST_WR_HOLD: begin
					o_we_b         <= 1'b1;
					state          <= ST_GAP;
				end
				ST_RD: begin
					cnt <= cnt - 4'h1;
					if (cnt == 4'h1) begin
						rd_word        <= dq_level;
						o_oe_b         <= 1'b1;
						state          <= ST_GAP;
					end
				end
				ST_GAP: begin
					o_ce_b  <= 1'b1;
					o_dq_oe <= 1'b0;
					state   <= ST_STEP;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequence and status evaluation, done in the gap after each bus cycle

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			phase        <= PH_CMD;
			step         <= 3'h0;
			req          <= '0;
			o_done       <= 1'b0;
			o_rdata      <= '0;
			o_lock_state <= 2'h0;
			o_fail       <= 1'b0;
			o_vpp_fault  <= 1'b0;
			o_cfg        <= CFG_RESET;
			prev_word    <= '0;
			prev_valid   <= 1'b0;
			fault_seen   <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (state == ST_IDLE && i_req_valid) begin
				req        <= i_req;
				step       <= 3'h0;
				phase      <= (seq_len(i_req.cmd) == 3'h0) ? PH_READ : PH_CMD;
				prev_valid <= 1'b0;
				fault_seen <= 1'b0;
				if (i_req.cmd == FLS_ID_EXIT) begin
					o_fail      <= 1'b0;
					o_vpp_fault <= 1'b0;
				end
			end else if (state == ST_GAP) begin
				unique case (phase)
					PH_CMD: begin
						if (step + 3'h1 < seq_len(req.cmd)) begin
							step <= step + 3'h1;
						end else begin
							step <= 3'h0;
							unique case (req.cmd)
								FLS_PROGRAM, FLS_ERASE_SECTOR: phase <= PH_POLL;
								FLS_READ_LOCK: phase <= PH_READ;
								FLS_SET_CFG: begin
									// Only this sequence moves the copy; device reset does not
									o_cfg  <= req.data[1:0];
									o_done <= 1'b1;
								end
								default: o_done <= 1'b1;
							endcase
						end
					end
					PH_READ: begin
						if (req.cmd == FLS_READ_LOCK) begin
							o_lock_state <= {rd_word[BIT_PERSISTENT],
								rd_word[BIT_VOLATILE]};
							phase <= PH_EXIT;
						end else begin
							o_rdata <= rd_word;
							phase   <= PH_CMD;
							o_done  <= 1'b1;
						end
					end
					PH_POLL: begin
						prev_word  <= rd_word;
						prev_valid <= 1'b1;
						if (prev_valid) begin
							// Bit 6 toggles while busy; 5 and 3 judge the outcome
							if (rd_word[BIT_TOGGLE] != prev_word[BIT_TOGGLE]) begin
								if (rd_word[BIT_FAILURE] | rd_word[BIT_VPP_FAULT]) begin
									if (fault_seen) begin
										o_fail      <= rd_word[BIT_FAILURE];
										o_vpp_fault <= rd_word[BIT_VPP_FAULT];
										phase       <= PH_EXIT;
									end
									fault_seen <= 1'b1;
									prev_valid <= 1'b0;
								end
							end else if (o_cfg == CFG_HOLD_STATUS) begin
								// Status held: bit 7 high marks completion
								o_fail      <= rd_word[BIT_FAILURE] | ~rd_word[BIT_POLLING];
								o_vpp_fault <= rd_word[BIT_VPP_FAULT];
								phase       <= PH_EXIT;
							end else begin
								o_rdata <= rd_word;
								phase   <= PH_CMD;
								o_done  <= 1'b1;
							end
						end
					end
					PH_EXIT: begin
						phase  <= PH_CMD;
						o_done <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule // fls_ctrl

// ==== fls_ctrl_chk.sv ====
`timescale 1ns/1ps
module fls_ctrl_chk
	import fls_pkg::*;
(
	input  wire logic                       i_mclk,        // Clock
	input  wire logic                       i_rst_b,       // Reset
	input  wire logic                       i_req_valid,   // Strobe
	input  wire logic                       i_flash_reset, // Dev reset
	input  wire logic                       o_req_ready,   // Ready
	input  wire logic                       o_done,        // Done
	input  wire logic                       o_fail,        // Fail
	input  wire logic [1:0]                 o_cfg,         // Config
	input  wire logic                       o_ce_b,        // CE
	input  wire logic                       o_oe_b,        // OE
	input  wire logic                       o_we_b,        // WE
	input  wire logic                       o_reset_b,     // Reset pin
	input  wire logic [fls_pkg::ADDR_W-1:0] o_addr,        // Address
	input  wire logic [fls_pkg::DATA_W-1:0] o_dq,          // Data
	input  wire logic                       o_dq_oe        // Drive
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	sequence s_wr_pulse;
		!o_we_b[*2] ##1 o_we_b;
	endsequence
	sequence s_rd_pulse;
		!o_oe_b[*7] ##1 o_oe_b;
	endsequence
	AST_WE_LEN: assert property ($fell(o_we_b) |-> s_wr_pulse)
		else $error("write pulse length wrong");
	AST_WR_CTL: assert property (!o_we_b |-> !o_ce_b && o_oe_b && o_dq_oe)
		else $error("write strobe without select");
	AST_WR_HOLD: assert property ($rose(o_we_b) |-> !o_ce_b && $stable(o_addr) && $stable(o_dq))
		else $error("write not held after strobe");
	AST_RD_LEN: assert property ($fell(o_oe_b) |-> !o_ce_b throughout s_rd_pulse)
		else $error("read cycle length wrong");
	AST_NO_FIGHT: assert property (!o_oe_b |-> !o_dq_oe && o_we_b)
		else $error("data bus contention");
	AST_RST_PIN: assert property ($past(i_rst_b) |-> o_reset_b == !$past(i_flash_reset))
		else $error("reset pin does not follow request");
	AST_CFG_RST: assert property ($rose(i_rst_b) |-> o_cfg == CFG_RESET)
		else $error("configuration not cleared");
	AST_CFG_IDLE: assert property ($past(i_rst_b) && $past(o_req_ready) && !$past(i_req_valid)
		|-> $stable(o_cfg))
		else $error("configuration changed while idle");
	AST_FAIL_IDLE: assert property ($past(i_rst_b) && $past(o_req_ready) && !$past(i_req_valid)
		|-> $stable(o_fail))
		else $error("failure flag changed while idle");
	AST_DONE_BUSY: assert property (o_done |-> !o_req_ready)
		else $error("ready during done");
endmodule // fls_ctrl_chk

// ==== fls_dev.sv ====
`timescale 1ns/1ps
module fls_dev
	import fls_pkg::*;
(
	input  wire logic                       i_mclk,    // Clock
	input  wire logic                       i_ce_b,    // CE
	input  wire logic                       i_oe_b,    // OE
	input  wire logic                       i_we_b,    // WE
	input  wire logic                       i_reset_b, // Reset
	input  wire logic                       i_wp,      // Protect
	input  wire logic                       i_vpp_ok,  // Voltage good
	input  wire logic [fls_pkg::ADDR_W-1:0] i_addr,    // Address
	input  wire logic [fls_pkg::DATA_W-1:0] i_dq,      // Host data
	output logic      [fls_pkg::DATA_W-1:0] o_dq,      // Device data
	output logic                            o_drv      // Drives
);
	logic [3:0]        vol, per, n, la;
	logic [DATA_W-1:0] mem [16] = '{default: 16'hffff};
	logic [1:0]        cfg = CFG_RESET;
	logic              busy, stat, fail, vflt, idm, ers, tog, pw, po;
	logic [DATA_W-1:0] ld, sw, last = 16'h0;
	int                cnt;
	////////////////////////////////////////////////////////////////
	task automatic start(input logic er, input logic [1:0] s);
		ers <= er;
		ld <= i_dq;
		la <= i_addr[3:0];
		stat <= 1'b1;
		busy <= 1'b1;
		cnt <= 4;
		vflt <= !i_vpp_ok;
		fail <= !i_vpp_ok || vol[s] || (per[s] && !i_wp)
			|| (!er && |(i_dq & ~mem[i_addr[3:0]]));
	endtask
	always_comb begin
		sw = 16'hff00; // Junk in unused bits
		sw[7] = (cfg == CFG_AUTO_RETURN) ? (!ers && !ld[7]) : (!busy && !fail);
		sw[6] = tog;
		sw[5] = fail;
		sw[3] = vflt;
	end
	assign o_drv = !i_ce_b && !i_oe_b && i_reset_b;
	always_comb begin
		if (!o_drv) o_dq = ~last; // Released bus shows no stale word
		else if (stat) o_dq = sw;
		else if (idm && i_addr[15:0] == LOCK_OFFSET[15:0])
			o_dq = {14'h2a5a, per[i_addr[21:20]], vol[i_addr[21:20]]};
		else o_dq = mem[i_addr[3:0]];
	end
	////////////////////////////////////////////////////////////////
	always @(posedge i_mclk) begin
		pw <= i_we_b;
		po <= i_oe_b;
		if (o_drv) last <= o_dq;
		if (!i_reset_b) begin
			vol <= 4'hf;
			per <= 4'h0;
			{n, busy, stat, fail, vflt, idm, tog} <= '0;
		end else if (!pw && i_we_b && !i_ce_b) begin
			n <= 4'h0;
			case (n)
				4'h0: begin
					if (i_dq == UNL_D1) n <= 4'h1;
					if (i_dq == UNLOCK1_D) n <= 4'h8;
					if (i_dq == ID_EXIT_D) {stat, fail, vflt, idm, busy} <= '0;
				end
				4'h1: if (i_dq == UNL_D2) n <= 4'h2;
				4'h2: begin
					if (i_dq == PROG_D) n <= 4'h3;
					if (i_dq == ERASE_SETUP_D) n <= 4'h4;
					if (i_dq == CFG_SET_D) n <= 4'h7;
					if (i_dq == ID_ENTRY_D) idm <= 1'b1;
				end
				4'h3: start(1'b0, i_addr[21:20]);
				4'h4: if (i_dq == UNL_D1) n <= 4'h5;
				4'h5: if (i_dq == UNL_D2) n <= 4'h6;
				4'h6: if (i_dq == SECTOR_ERASE_D) start(1'b1, i_addr[21:20]);
				4'h7: cfg <= i_dq[1:0];
				4'h8: if (i_dq == UNLOCK2_D && (i_wp || !per[i_addr[21:20]]))
					vol[i_addr[21:20]] <= 1'b0;
				default: ;
			endcase
		end else if (!po && i_oe_b && busy) begin
			tog <= !tog; // Failure keeps toggling
			cnt <= cnt - 1;
			if (cnt == 1 && !fail) begin
				busy <= 1'b0;
				stat <= (cfg == CFG_HOLD_STATUS);
				if (ers) mem <= '{default: 16'hffff};
				else mem[la] <= ld;
			end
		end
	end
endmodule // fls_dev

// ==== tb.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
	$display("wrong value at %0t: got %h, expected %h", $time, a, b); end end
module tb;
	import fls_pkg::*;
	logic              i_mclk = 1'b0, i_rst_b = 1'b0, i_req_valid = 1'b0, vpp_ok = 1'b1;
	logic              i_write_protect = 1'b0, i_flash_reset = 1'b0;
	fls_req_t          i_req = '0;
	logic              o_req_ready, o_done, o_fail, o_vpp_fault, o_ce_b, o_oe_b, o_we_b;
	logic              o_reset_b, o_wp, o_dq_oe, dev_drv;
	logic [1:0]        o_lock_state, o_cfg;
	logic [DATA_W-1:0] o_rdata, o_dq, dev_dq, i_dq, d;
	logic [ADDR_W-1:0] o_addr;
	logic [15:0]       rnd = 16'h005f;
	int                failures = 0, checked = 0, cycles = 0;

	assign i_dq = o_dq_oe ? o_dq : dev_dq;
	fls_ctrl dut (.i_mclk, .i_rst_b, .i_req, .i_req_valid, .o_req_ready, .o_done, .o_rdata,
		.o_lock_state, .o_fail, .o_vpp_fault, .o_cfg, .i_write_protect, .i_flash_reset,
		.o_ce_b, .o_oe_b, .o_we_b, .o_reset_b, .o_wp, .o_addr, .o_dq, .o_dq_oe, .i_dq);
	fls_dev m (.i_mclk, .i_ce_b(o_ce_b), .i_oe_b(o_oe_b), .i_we_b(o_we_b), .i_reset_b(o_reset_b),
		.i_wp(o_wp), .i_vpp_ok(vpp_ok), .i_addr(o_addr), .i_dq(o_dq), .o_dq(dev_dq), .o_drv(dev_drv));
	initial forever #12.5 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [15:0] next_rnd();
		rnd = rnd ^ (rnd << 7);
		rnd = rnd ^ (rnd >> 9);
		rnd = rnd ^ (rnd << 8);
		return rnd;
	endfunction
	function automatic logic exp_fail(input logic p, input logic v);
		return !vpp_ok || v || (p && !i_write_protect);
	endfunction
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic req(input fls_cmd_t c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(negedge i_mclk);
		i_req = '{cmd: c, addr: a, data: v};
		i_req_valid = 1'b1;
		while (o_req_ready !== 1'b1) @(negedge i_mclk);
		@(negedge i_mclk);
		i_req_valid = 1'b0;
		while (o_done !== 1'b1) @(negedge i_mclk);
	endtask
	task automatic lock(input logic [1:0] s, input logic [1:0] e);
		req(FLS_READ_LOCK, {s, 20'h0}, 16'h0);
		`CHK(o_lock_state, e)
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		req(FLS_READ, a, 16'h0);
		`CHK(o_rdata, e)
	endtask
	task automatic op(input fls_cmd_t c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v,
		input logic f);
		req(c, a, v);
		`CHK(o_fail, f)
		`CHK(o_vpp_fault, !vpp_ok)
		if (f) begin
			req(FLS_ID_EXIT, 22'h0, 16'h0);
			`CHK(o_fail, 1'b0)
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(negedge i_mclk);
		i_rst_b = 1'b1;
		`CHK(o_cfg, CFG_RESET)
		lock(2'h0, 2'b01);
		op(FLS_PROGRAM, 22'h4, 16'h1234, exp_fail(1'b0, 1'b1));
		rd(22'h4, 16'hffff);
		$display("test protect finished");
		req(FLS_UNLOCK, 22'h0, 16'h0);
		lock(2'h0, 2'b00);
		for (int i = 0; i < 6; i++) begin
			d = (i < 4) ? next_rnd() : {8'h0, i[0], 7'h0};
			op(FLS_PROGRAM, 22'(i), d, 1'b0);
			rd(22'(i), d);
		end
		op(FLS_PROGRAM, 22'h5, 16'hffff, 1'b1);
		op(FLS_ERASE_SECTOR, 22'h0, 16'h0, 1'b0);
		rd(22'h5, 16'hffff);
		vpp_ok = 1'b0;
		op(FLS_PROGRAM, 22'h7, 16'h0, exp_fail(1'b0, 1'b0));
		vpp_ok = 1'b1;
		$display("test program finished");
		m.per[1] = 1'b1;
		req(FLS_UNLOCK, 22'h100000, 16'h0);
		lock(2'h1, 2'b11);
		op(FLS_PROGRAM, 22'h100001, 16'h0, exp_fail(1'b1, 1'b1));
		i_write_protect = 1'b1;
		req(FLS_UNLOCK, 22'h100000, 16'h0);
		lock(2'h1, 2'b10);
		op(FLS_PROGRAM, 22'h100001, 16'h5a5a, exp_fail(1'b1, 1'b0));
		$display("test hardlock finished");
		req(FLS_SET_CFG, 22'h0, 16'h0001);
		`CHK(o_cfg, CFG_HOLD_STATUS)
		d = next_rnd();
		op(FLS_PROGRAM, 22'h100002, d, 1'b0);
		rd(22'h100002, d);
		op(FLS_ERASE_SECTOR, 22'h100000, 16'h0, 1'b0);
		op(FLS_PROGRAM, 22'h200000, 16'h0, exp_fail(1'b0, 1'b1));
		i_flash_reset = 1'b1;
		repeat (4) @(negedge i_mclk);
		i_flash_reset = 1'b0;
		repeat (3) @(negedge i_mclk);
		`CHK(o_cfg, CFG_HOLD_STATUS)
		lock(2'h1, 2'b01);
		$display("test config finished");
		give_verdict();
	end
endmodule // tb
bind fls_ctrl fls_ctrl_chk u_chk (.i_mclk, .i_rst_b, .i_req_valid, .i_flash_reset, .o_req_ready,
	.o_done, .o_fail, .o_cfg, .o_ce_b, .o_oe_b, .o_we_b, .o_reset_b, .o_addr, .o_dq, .o_dq_oe);
